//--- logic/bffu_map.vh
// constants for the burst flash fetch unit
`ifndef BFFU_MAP_VH
`define BFFU_MAP_VH
// word step of the 32-bit burst interface, in bytes
`define BFFU_WORD_STEP   32'h00000004
// bytes covered by the four instructions held per branch entry
`define BFFU_ENTRY_BYTES 32'h00000010
// prefetch queue depth in instructions
`define BFFU_QDEPTH      3'h4
// instructions held per branch cache entry
`define BFFU_ENTRY_WORDS 3'h4
// highest burst fetch rate the flash side supports, in MHz
`define BFFU_FETCH_MHZ   96
// recency ages after reset: entry 0 youngest, entry 3 oldest
`define BFFU_AGE_RESET   8'he4
`endif

//--- logic/bffu_top.v
// burst flash fetch unit: prefetch queue, branch target cache and flash port
// Overview of operation
// RULE1 - read flash over dedicated 32-bit burst port
// RULE2 - queue holds four instructions ahead
// RULE3 - four general branch cache entries beside queue
// RULE4 - keep prefetching in every idle flash cycle (code issues no prefetch while the queue is full or a literal read waits)
// RULE5 - one 32-bit word per prefetch, up to 96 MHz
// RULE6 - non-sequential address checks branch cache first
// RULE7 - entry holds target and first four instructions
// RULE8 - all four tags compared in parallel
// RULE9 - hit feeds cached words, queue fetches beyond
// RULE10 - fifth entry reserved for interrupt vector read
// RULE11 - literal reads never flush the queue
// RULE12 - fifth entry permanently holds vector-read instruction
// RULE13 - miss stalls core, allocates least recent entry
// RULE14 - hits update recency order for replacement
`include "bffu_map.vh"
`timescale 1ns/1ps
`default_nettype none
module bffu_top #(
  parameter [31:0] VEC_INSTR = 32'h00000000
)(
  // clock, reset, enable
  input  wire        clock,
  input  wire        srst,
  input  wire        clk_en,
  // core instruction port
  input  wire        core_req,
  input  wire [31:0] core_addr,
  input  wire        core_literal,
  input  wire        core_irq_vec,
  output reg         core_ack,
  output reg  [31:0] core_rdata,
  output reg         core_stall,
  output reg         bc_hit,
  // flash burst port
  output reg         flash_req,
  output reg  [31:0] flash_addr,
  output reg         flash_seq,
  input  wire        flash_valid,
  input  wire [31:0] flash_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  function [1:0] age_of;
    input [7:0] ages;
    input [1:0] idx;
    begin
      age_of = ages[{idx, 1'b0} +: 2];
    end
  endfunction

  // invalid entries are filled first, else the oldest one
  function [1:0] pick_victim;
    input [3:0] val;
    input [7:0] ages;
    integer     k;
    begin
      pick_victim = 2'h0;
      for (k = 3; k >= 0; k = k - 1)
        if (age_of(ages, k[1:0]) == 2'h3)
          pick_victim = k[1:0];
      for (k = 3; k >= 0; k = k - 1)
        if (!val[k])
          pick_victim = k[1:0];
    end
  endfunction

  function [7:0] touch;
    input [7:0] ages;
    input [1:0] idx;
    integer     k;
    reg   [1:0] a;
    begin
      a = age_of(ages, idx);
      touch = ages;
      for (k = 0; k < 4; k = k + 1)
        if (k[1:0] == idx)
          touch[2*k +: 2] = 2'h0;
        else if (age_of(ages, k[1:0]) < a)
          touch[2*k +: 2] = age_of(ages, k[1:0]) + 2'h1;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // storage
  reg [31:0] q_mem [0:3];
  reg [31:0] bc_data [0:15];
  reg [31:0] bc_tag [0:3];
  reg [1:0]  q_rd_reg;
  reg [1:0]  q_wr_reg;
  reg [2:0]  q_cnt_reg;
  reg [31:0] q_addr_reg;
  reg [31:0] f_addr_reg;
  reg        busy_reg;
  reg        busy_lit_reg;
  reg        drop_reg;
  reg        seq_ok_reg;
  reg        alloc_reg;
  reg [1:0]  alloc_idx_reg;
  reg [1:0]  alloc_cnt_reg;
  reg [31:0] alloc_tag_reg;
  reg [3:0]  bc_val_reg;
  reg [7:0]  bc_age_reg;

  ////////////////////////////////////////////////////////////////////////////
  // request decode
  reg        take;
  reg        in_stream;
  reg [3:0]  hit_vec;
  reg        hit;
  reg [1:0]  hit_idx;
  reg        pop;
  reg        flush;
  reg        ret;
  reg        push;
  reg        lit_issue;
  reg        can_issue;
  reg        pf_issue;
  reg [2:0]  cnt_next;
  reg        ack_next;
  reg [31:0] data_next;
  reg        alloc_done;
  integer    i;
  integer    j;

  always @*
  begin
    take      = core_req & ~core_ack;
    in_stream = core_addr == q_addr_reg;
    hit_idx   = 2'h0;
    for (i = 0; i < 4; i = i + 1)
    begin
      hit_vec[i] = bc_val_reg[i] & (bc_tag[i] == core_addr);  // see RULE8
      if (hit_vec[i])
        hit_idx = i[1:0];
    end
    hit   = |hit_vec;
    // literal and vector reads bypass the stream test entirely
    pop   = take & ~core_literal & ~core_irq_vec & in_stream
            & (q_cnt_reg != 3'h0);                            // see RULE2
    flush = take & ~core_literal & ~core_irq_vec & ~in_stream; // see RULE11
    ret   = flash_valid & busy_reg;
    push  = ret & ~busy_lit_reg & ~drop_reg & ~flush;
    can_issue = ~busy_reg | ret;                              // see RULE4
    lit_issue = take & core_literal & ~busy_lit_reg & can_issue;
    if (flush)
      cnt_next = hit ? 3'h3 : 3'h0;                           // see RULE9
    else
      cnt_next = q_cnt_reg + {2'h0, push} - {2'h0, pop};
    pf_issue = can_issue & ~lit_issue & (cnt_next < `BFFU_QDEPTH)
               & ~(take & core_literal);
    alloc_done = push & alloc_reg & (alloc_cnt_reg == 2'h3);
    ack_next  = 1'b0;
    data_next = core_rdata;
    if (take & core_irq_vec)
    begin
      ack_next  = 1'b1;
      data_next = VEC_INSTR;                                  // see RULE10, RULE12
    end
    else if (pop)
    begin
      ack_next  = 1'b1;
      data_next = q_mem[q_rd_reg];
    end
    else if (flush & hit)
    begin
      ack_next  = 1'b1;
      data_next = bc_data[{hit_idx, 2'h0}];                   // see RULE9
    end
    else if (ret & busy_lit_reg)
    begin
      ack_next  = 1'b1;
      data_next = flash_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // queue, flash port and core answer
  always @(posedge clock)
  begin
    if (srst)
    begin
      q_rd_reg     <= 2'h0;
      q_wr_reg     <= 2'h0;
      q_cnt_reg    <= 3'h0;
      q_addr_reg   <= 32'h00000000;
      f_addr_reg   <= 32'h00000000;
      busy_reg     <= 1'b0;
      busy_lit_reg <= 1'b0;
      drop_reg     <= 1'b0;
      seq_ok_reg   <= 1'b0;
      core_ack     <= 1'b0;
      core_rdata   <= 32'h00000000;
      core_stall   <= 1'b0;
      bc_hit       <= 1'b0;
      flash_req    <= 1'b0;
      flash_addr   <= 32'h00000000;
      flash_seq    <= 1'b0;
    end
    else if (clk_en)
    begin
      core_ack   <= ack_next;
      core_rdata <= data_next;
      core_stall <= take & ~ack_next;                         // see RULE13
      bc_hit     <= flush & hit;
      q_cnt_reg  <= cnt_next;
      if (flush)
      begin
        // a hit preloads the three remaining cached words
        for (j = 0; j < 3; j = j + 1)
          q_mem[j] <= bc_data[{hit_idx, 2'h1 + j[1:0]}];
        q_rd_reg   <= 2'h0;
        q_wr_reg   <= hit ? 2'h3 : 2'h0;
        q_addr_reg <= hit ? core_addr + `BFFU_WORD_STEP : core_addr;  // see RULE6
        // a word still in flight belongs to the old stream
        drop_reg   <= busy_reg & ~ret;
      end
      else
      begin
        if (push)
        begin
          q_mem[q_wr_reg] <= flash_rdata;                     // see RULE5
          q_wr_reg        <= q_wr_reg + 2'h1;
        end
        if (pop)
        begin
          q_rd_reg   <= q_rd_reg + 2'h1;
          q_addr_reg <= q_addr_reg + `BFFU_WORD_STEP;
        end
        if (ret)
          drop_reg <= 1'b0;
      end
      flash_req <= lit_issue | pf_issue;                      // see RULE1
      flash_seq <= pf_issue & seq_ok_reg & ~flush;
      if (lit_issue)
      begin
        flash_addr <= core_addr;
        seq_ok_reg <= 1'b0;
      end
      else if (pf_issue)
      begin
        if (flush)
          flash_addr <= hit ? core_addr + `BFFU_ENTRY_BYTES : core_addr;
        else
          flash_addr <= f_addr_reg;
        seq_ok_reg <= 1'b1;
      end
      else if (flush)
        seq_ok_reg <= 1'b0;
      if (flush)
        f_addr_reg <= (hit ? core_addr + `BFFU_ENTRY_BYTES : core_addr)
                      + (pf_issue ? `BFFU_WORD_STEP : 32'h00000000);
      else if (pf_issue)
        f_addr_reg <= f_addr_reg + `BFFU_WORD_STEP;
      if (lit_issue | pf_issue)
      begin
        busy_reg     <= 1'b1;
        busy_lit_reg <= lit_issue;
      end
      else if (ret)
      begin
        busy_reg     <= 1'b0;
        busy_lit_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // branch cache allocation and recency
  always @(posedge clock)
  begin
    if (srst)
    begin
      alloc_reg     <= 1'b0;
      alloc_idx_reg <= 2'h0;
      alloc_cnt_reg <= 2'h0;
      alloc_tag_reg <= 32'h00000000;
      bc_val_reg    <= 4'h0;
      bc_age_reg    <= `BFFU_AGE_RESET;
    end
    else if (clk_en)
    begin
      if (flush & hit)
      begin
        alloc_reg  <= 1'b0;
        bc_age_reg <= touch(bc_age_reg, hit_idx);             // see RULE14
      end
      else if (flush)
      begin
        // the victim is invalid until all four words have landed
        alloc_reg     <= 1'b1;
        alloc_idx_reg <= pick_victim(bc_val_reg, bc_age_reg);  // see RULE13
        alloc_cnt_reg <= 2'h0;
        alloc_tag_reg <= core_addr;
        bc_val_reg[pick_victim(bc_val_reg, bc_age_reg)] <= 1'b0;
      end
      else if (push & alloc_reg)
      begin
        bc_data[{alloc_idx_reg, alloc_cnt_reg}] <= flash_rdata;  // see RULE7
        alloc_cnt_reg <= alloc_cnt_reg + 2'h1;
        if (alloc_done)
        begin
          alloc_reg                 <= 1'b0;
          bc_tag[alloc_idx_reg]     <= alloc_tag_reg;
          bc_val_reg[alloc_idx_reg] <= 1'b1;                  // see RULE3
          bc_age_reg                <= touch(bc_age_reg, alloc_idx_reg);
        end
      end
    end
  end

endmodule
`default_nettype wire

//--- verif/bffu_checker.sv
// assertion checker for the burst flash fetch unit
`timescale 1ns/1ps
`default_nettype none
module bffu_checker #(
  parameter [31:0] VEC_INSTR = 32'h00000000
)(
  // clock and reset
  input wire logic        clock,
  input wire logic        srst,
  // core side
  input wire logic        core_req,
  input wire logic        core_irq_vec,
  input wire logic        core_ack,
  input wire logic [31:0] core_rdata,
  input wire logic        core_stall,
  input wire logic        bc_hit,
  // flash side
  input wire logic        flash_req,
  input wire logic [31:0] flash_addr,
  input wire logic        flash_seq,
  input wire logic        flash_valid
);
  // high while a flash read waits for its answer
  logic pend_reg;
  always @(posedge clock)
  begin
    pend_reg <= !srst && (flash_req || (pend_reg && !flash_valid));
  end
  // address of the last flash read, to judge burst continuations
  logic [31:0] last_addr_reg;
  always @(posedge clock)
  begin
    if (flash_req)
      last_addr_reg <= flash_addr;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  //////////////////////////////////////////////////////////////////////////////
  a_ack_pulse: assert property (core_ack |=> !core_ack)
    else $error("core ack longer than one cycle");
  a_one_read: assert property (flash_req |-> !pend_reg || flash_valid)
    else $error("second flash read before answer");
  a_vec_fast: assert property (core_req && core_irq_vec && !core_ack
    |=> core_ack && core_rdata == VEC_INSTR) else $error("vector read not answered at once");
  a_hit_ack: assert property (bc_hit |-> core_ack)
    else $error("branch hit without answer");
  a_stall_end: assert property (core_stall |-> ##[0:40] core_ack)
    else $error("stall never ends");
  a_data_hold: assert property (!core_ack |-> $stable(core_rdata))
    else $error("core data moved without ack");
  a_addr_hold: assert property (!flash_req |-> $stable(flash_addr))
    else $error("flash address moved without read");
  a_reset_idle: assert property ($past(srst) |-> !(core_ack || flash_req || bc_hit))
    else $error("activity right after reset");
  a_seq_step: assert property (flash_seq |-> flash_req && flash_addr == last_addr_reg + 32'h4)
    else $error("burst continuation not one word on");
  c_hit: cover property (bc_hit);
  c_burst: cover property (flash_req && flash_seq);
  c_vec: cover property (core_ack && core_irq_vec);
endmodule
bind bffu_top bffu_checker #(.VEC_INSTR(VEC_INSTR)) chk (.clock, .srst, .core_req, .core_irq_vec,
  .core_ack, .core_rdata, .core_stall, .bc_hit, .flash_req, .flash_addr, .flash_seq, .flash_valid);
`default_nettype wire

//--- verif/bffu_flash_model.sv
// flash die model: answers each read after a random 1 to 4 cycle delay
`timescale 1ns/1ps
`default_nettype none
module bffu_flash_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // burst read port
  input  wire logic        flash_req,
  input  wire logic [31:0] flash_addr,
  output var  logic        flash_valid,
  output var  logic [31:0] flash_rdata
);
  logic [31:0] addr_reg;
  logic        busy_reg;
  int          wait_reg;
  always @(posedge clock)
  begin
    flash_valid <= 1'b0;
    // idle data toggles so a stale word is never mistaken for an answer
    flash_rdata <= ~flash_rdata;
    if (srst)
    begin
      busy_reg    <= 1'b0;
      flash_rdata <= 32'h0;
    end
    else if (busy_reg && wait_reg == 0)
    begin
      busy_reg    <= 1'b0;
      flash_valid <= 1'b1;
      flash_rdata <= {addr_reg[15:0] ^ 16'h3c5a, addr_reg[15:0]};
    end
    else if (busy_reg)
      wait_reg <= wait_reg - 1;
    if (flash_req && !srst)
    begin
      busy_reg <= 1'b1;
      addr_reg <= flash_addr;
      wait_reg <= $urandom_range(3, 0);
    end
  end
endmodule
`default_nettype wire

//--- verif/tb_burst_flash_fetch_unit.sv
// self-checking bench for the burst flash fetch unit
`timescale 1ns/1ps
`default_nettype none
module tb_burst_flash_fetch_unit;
  localparam logic [31:0] VEC = 32'h1f2e3d4c; // arbitrary vector-read instruction
  logic             clock, srst, core_req, core_literal, core_irq_vec;
  logic [31:0]      core_addr, t;
  wire logic        core_ack, core_stall, bc_hit, flash_req, flash_seq, flash_valid;
  wire logic [31:0] core_rdata, flash_addr, flash_rdata;
  int               errors = 0;
  int               cmp_count = 0;
  int               i;
  bffu_top #(.VEC_INSTR(VEC)) uut (.clock, .srst, .clk_en(1'b1), .core_req, .core_addr,
    .core_literal, .core_irq_vec, .core_ack, .core_rdata, .core_stall, .bc_hit, .flash_req,
    .flash_addr, .flash_seq, .flash_valid, .flash_rdata);
  bffu_flash_model far (.clock, .srst, .flash_req, .flash_addr, .flash_valid, .flash_rdata);
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  function automatic logic [31:0] word_at(input logic [31:0] a);
    return {a[15:0] ^ 16'h3c5a, a[15:0]};
  endfunction
  task automatic finish_test();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request stays up after ack; each fetch drives it high again with the new address
  task automatic fetch(input logic [31:0] a, input logic lit, input logic vec, input int hit_exp);
    int   n;
    logic hit;
    n = 0;
    hit = 1'b0;
    core_req <= 1'b1;
    core_addr <= a;
    core_literal <= lit;
    core_irq_vec <= vec;
    do
    begin
      @(posedge clock);
      n++;
      hit = hit | bc_hit;
    end
    while (core_ack !== 1'b1 && n < 60);
    if (core_ack !== 1'b1)
    begin
      errors++;
      $display("[ERR] %0t ack timeout got %h exp %h", $time, core_ack, 1'b1);
      finish_test();
    end
    else
    begin
      check32(core_rdata, vec ? VEC : word_at(a));
      if (hit_exp != 2)
        check32({31'h0, hit}, hit_exp[31:0]);
    end
  endtask
  // branch to a, then walk on sequentially; hit_exp 2 leaves the hit unjudged
  task automatic run(input logic [31:0] a, input int hit_exp, input int len);
    fetch(a, 1'b0, 1'b0, hit_exp);
    for (int k = 1; k < len; k++)
      fetch(a + 32'(4 * k), 1'b0, 1'b0, 0);
  endtask
  initial
  begin
    srst = 1'b1;
    core_req = 1'b0;
    core_addr = 32'h0;
    core_literal = 1'b0;
    core_irq_vec = 1'b0;
    void'($urandom(32'h0ae8));
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    run(32'h100, 0, 8);
    run(32'h400, 0, 3);
    fetch(32'h800, 1'b1, 1'b0, 0);
    fetch(32'h40c, 1'b0, 1'b0, 0);
    fetch(32'h0, 1'b0, 1'b1, 0);
    fetch(32'h410, 1'b0, 1'b0, 0);
    run(32'h100, 1, 6);
    run(32'h400, 1, 5);
    run(32'h1000, 0, 5);
    run(32'h2000, 0, 5);
    run(32'h100, 1, 5);
    run(32'h3000, 0, 5);
    run(32'h1000, 1, 5);
    run(32'h2000, 1, 5);
    run(32'h3000, 1, 5);
    run(32'h100, 1, 5);
    run(32'h400, 0, 5);
    for (i = 0; i < 40; i++)
    begin
      t = $urandom & 32'h0000fffc;
      run(t, 2, $urandom_range(6, 1));
      fetch(t ^ 32'h8000, 1'b1, 1'b0, 0);
    end
    core_req <= 1'b0;
    finish_test();
  end
endmodule
`default_nettype wire
